// File: hdl/isp_pkg.sv
// shared constants and types of the instrument serial slave port
package isp_pkg;

    // ********************************
    // frame geometry
    // ********************************
    localparam int ADDR_BITS  = 8;   // unit address length
    localparam int FRAME_BITS = 48;  // configuration frame length
    localparam int CONV_BITS  = 17;  // half digit plus four bcd digits
    localparam int CNT_BITS   = 6;   // bit counter width
    localparam int PREV_BITS  = FRAME_BITS - CONV_BITS;

    // ********************************
    // counts and reset values
    // ********************************
    localparam logic [2:0] STROBE_EDGES = 3'h6;  // three full data cycles
    localparam logic [2:0] EDGE_MAX     = 3'h7;
    localparam logic [CNT_BITS-1:0] CNT_ADDR  = 6'h08;
    localparam logic [CNT_BITS-1:0] CNT_FRAME = 6'h30;
    localparam logic [CNT_BITS-1:0] CNT_MAX   = 6'h3F;
    localparam logic [FRAME_BITS-1:0] SETTINGS_RST = 48'h0000_0000_0000;
    localparam int FIFO_DEPTH = 4;

    // ********************************
    // types
    // ********************************
    typedef enum logic [1:0] {
        ST_ADDR   = 2'h0,
        ST_DATA   = 2'h1,
        ST_COMMIT = 2'h3
    } isp_fsm_type;

    typedef struct packed {
        logic clk;
        logic dat;
    } isp_pin_type;

    typedef struct packed {
        isp_pin_type                 s1;        // first synchroniser stage
        isp_pin_type                 s2;        // second synchroniser stage
        isp_pin_type                 prev;      // last synchronised level
        logic [ADDR_BITS-1:0]        addr_s1;
        logic [ADDR_BITS-1:0]        addr_s2;
        logic [2:0]                  edge_cnt;  // data edges while clock low
        logic [CNT_BITS-1:0]         bit_cnt;   // rising clock edges seen
        isp_fsm_type                 fsm;
        logic [FRAME_BITS-1:0]       frame;     // word being returned
        logic [FRAME_BITS-1:0]       capture;   // received frame
        logic [FRAME_BITS-1:0]       settings;  // parallel latches
        logic                        dline;     // instrument data line
    } isp_sys_state_type;

    typedef struct packed {
        logic [FRAME_BITS-1:0] shift;
    } isp_link_state_type;

endpackage

// File: hdl/isp_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module isp_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr;
        logic [PW-1:0]               rd;
        logic [CW-1:0]               cnt;
    } isp_fifo_state_type;

    isp_fifo_state_type st_q;
    isp_fifo_state_type st_d;
    logic               push;
    logic               pop;

    // honest flags straight from the fill count
    assign in_ready_o  = (st_q.cnt != CW'(DEPTH));
    assign out_valid_o = (st_q.cnt != '0);
    assign out_data_o  = st_q.mem[st_q.rd];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // pointer wrap helper
    function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
        nxt = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // next state
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_data_i;
            st_d.wr           = nxt(st_q.wr);
        end
        if (pop) begin
            st_d.rd = nxt(st_q.rd);
        end
        if (push && !pop) begin
            st_d.cnt = CW'(st_q.cnt + 1'b1);
        end else if (pop && !push) begin
            st_d.cnt = CW'(st_q.cnt - 1'b1);
        end
    end

    // state register
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// File: hdl/isp_slave.sv
// instrument serial slave port: address, strobe and frame exchange
`timescale 1ns/1ns
module isp_slave #(
    parameter int FIFO_DEPTH = isp_pkg::FIFO_DEPTH
) (
    input  wire logic                          clk_sys_i,
    input  wire logic                          reset_n_i,
    input  wire logic                          bus_clock_line_i,
    input  wire logic                          host_data_line_i,
    output logic                               instrument_data_line_o,
    input  wire logic [isp_pkg::ADDR_BITS-1:0] unit_address_i,
    input  wire logic [isp_pkg::CONV_BITS-1:0] reading_i,
    input  wire logic                          local_mode_i,
    input  wire logic [isp_pkg::FRAME_BITS-1:0] panel_settings_i,
    output logic [isp_pkg::FRAME_BITS-1:0]     settings_o,
    output logic                               addressed_o,
    output logic                               frame_valid_o,
    input  wire logic                          frame_ready_i,
    output logic [isp_pkg::FRAME_BITS-1:0]     frame_data_o
);

    // ****************************************
    // link side: shift register on bus clock
    // ****************************************
    isp_pkg::isp_link_state_type lk_q;
    isp_pkg::isp_link_state_type lk_d;

    // shift in one bit per rising edge, newest bit lowest
    always_comb begin
        lk_d = lk_q;
        lk_d.shift = {lk_q.shift[isp_pkg::FRAME_BITS-2:0], host_data_line_i};
    end

    // link register, the line has no reset of its own
    always_ff @(posedge bus_clock_line_i) begin
        lk_q <= lk_d;
    end

    // ****************************************
    // system side
    // ****************************************
    isp_pkg::isp_sys_state_type st_q;
    isp_pkg::isp_sys_state_type st_d;
    logic                               clk_rise;
    logic                               dat_edge;
    logic                               strobe;
    logic                               addr_hit;
    logic                               push_ready;
    logic [isp_pkg::FRAME_BITS-1:0]     prev_cfg;

    // pick the response bit for a given bit count
    function automatic logic bit_pick(
        input logic [isp_pkg::FRAME_BITS-1:0] w,
        input logic [isp_pkg::CNT_BITS-1:0]   c
    );
        if (c < isp_pkg::CNT_FRAME) begin
            bit_pick = w[isp_pkg::CNT_FRAME - 6'h01 - c];
        end else begin
            bit_pick = 1'b0;
        end
    endfunction

    // saturating increment used by the bit counter
    function automatic logic [isp_pkg::CNT_BITS-1:0] sat_inc(
        input logic [isp_pkg::CNT_BITS-1:0] v,
        input logic [isp_pkg::CNT_BITS-1:0] lim
    );
        sat_inc = (v == lim) ? v : isp_pkg::CNT_BITS'(v + 1'b1);
    endfunction

    // events seen on the synchronised pins
    assign clk_rise = st_q.s2.clk && !st_q.prev.clk;
    assign dat_edge = (st_q.s2.dat != st_q.prev.dat) && !st_q.s2.clk;
    // six edges make three full cycles
    assign strobe   = dat_edge && (st_q.edge_cnt == isp_pkg::STROBE_EDGES - 3'h1);
    // msb arrived first, so it sits highest
    assign addr_hit = (lk_q.shift[isp_pkg::ADDR_BITS-1:0] == st_q.addr_s2);
    assign prev_cfg = local_mode_i ? panel_settings_i : st_q.settings;

    // next state
    always_comb begin
        st_d         = st_q;
        st_d.s1      = '{clk: bus_clock_line_i, dat: host_data_line_i};
        st_d.s2      = st_q.s1;
        st_d.prev    = st_q.s2;
        st_d.addr_s1 = unit_address_i;
        st_d.addr_s2 = st_q.addr_s1;
        // clock high clears the toggle count; a normal bit
        // moves the data line at most twice while clock is low
        if (st_q.s2.clk) begin
            st_d.edge_cnt = 3'h0;
        end else if (dat_edge && st_q.edge_cnt != isp_pkg::EDGE_MAX) begin
            st_d.edge_cnt = 3'(st_q.edge_cnt + 1'b1);
        end
        // count bits since the last strobe
        if (strobe) begin
            st_d.bit_cnt = '0;
        end else if (clk_rise) begin
            st_d.bit_cnt = sat_inc(st_q.bit_cnt, isp_pkg::CNT_MAX);
        end
        // the link shift word is read only after a strobe, when
        // the bus clock has stood low for many system cycles
        case (st_q.fsm)
            isp_pkg::ST_ADDR: begin
                if (strobe && st_q.bit_cnt == isp_pkg::CNT_ADDR) begin
                    if (addr_hit) begin
                        st_d.fsm   = isp_pkg::ST_DATA;
                        st_d.frame = {reading_i,
                                      prev_cfg[isp_pkg::PREV_BITS-1:0]};
                    end
                end
            end
            isp_pkg::ST_DATA: begin
                if (strobe) begin
                    // only a full frame is taken
                    if (st_q.bit_cnt == isp_pkg::CNT_FRAME) begin
                        st_d.capture = lk_q.shift;
                        st_d.fsm     = isp_pkg::ST_COMMIT;
                    end else begin
                        st_d.fsm = isp_pkg::ST_ADDR;
                    end
                end
            end
            isp_pkg::ST_COMMIT: begin
                if (push_ready) begin
                    st_d.settings = st_q.capture;
                    st_d.fsm      = isp_pkg::ST_ADDR;
                end
            end
            default: begin
                st_d.fsm = isp_pkg::ST_ADDR;
            end
        endcase
        // one response bit per bit count
        // changes only after a rising edge or a strobe
        if (st_d.fsm == isp_pkg::ST_DATA) begin
            st_d.dline = bit_pick(st_d.frame, st_d.bit_cnt);
        end else begin
            st_d.dline = 1'b0;
        end
    end

    // system register
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            st_q          <= '0;
            st_q.fsm      <= isp_pkg::ST_ADDR;
            st_q.settings <= isp_pkg::SETTINGS_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************
    // settings stream out through the fifo
    // ****************************************
    isp_fifo #(
        .WIDTH (isp_pkg::FRAME_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .in_valid_i  (st_q.fsm == isp_pkg::ST_COMMIT),
        .in_ready_o  (push_ready),
        .in_data_i   (st_q.capture),
        .out_valid_o (frame_valid_o),
        .out_ready_i (frame_ready_i),
        .out_data_o  (frame_data_o)
    );

    // outputs from flip-flops; addressed_o is decoded from the state register
    assign instrument_data_line_o = st_q.dline;
    assign settings_o             = st_q.settings;
    assign addressed_o            = (st_q.fsm == isp_pkg::ST_DATA);

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_STROBE_CLOCK_LOW: assert property (
        strobe |-> !st_q.s2.clk && st_q.edge_cnt == 3'h5)
        else $error("strobe seen without clock low and five toggles");

    AST_STROBE_CLEARS_COUNT: assert property (
        strobe |=> st_q.bit_cnt == '0)
        else $error("bit count not cleared by strobe");

    AST_ADDR_MATCH: assert property (
        (st_q.fsm == isp_pkg::ST_ADDR && strobe && addr_hit &&
         st_q.bit_cnt == isp_pkg::CNT_ADDR) |=> addressed_o)
        else $error("matching address did not open data phase");

    AST_ADDR_MISS: assert property (
        (st_q.fsm == isp_pkg::ST_ADDR && strobe && !addr_hit)
        |=> st_q.fsm == isp_pkg::ST_ADDR)
        else $error("wrong address was accepted");

    AST_FRAME_COMMIT: assert property (
        (addressed_o && strobe && st_q.bit_cnt == isp_pkg::CNT_FRAME)
        |=> st_q.fsm == isp_pkg::ST_COMMIT &&
            st_q.capture == $past(lk_q.shift))
        else $error("full frame not captured on strobe");

    AST_LATCH_UPDATE: assert property (
        (st_q.fsm == isp_pkg::ST_COMMIT && push_ready)
        |=> settings_o == $past(st_q.capture) ##1 frame_valid_o)
        else $error("latches or stream not updated at commit");

    AST_RETURN_FRAME: assert property (
        $rose(addressed_o) |-> st_q.frame ==
            {$past(reading_i), $past(prev_cfg[isp_pkg::PREV_BITS-1:0])})
        else $error("returned frame does not hold previous state");

    AST_LINE_QUIET: assert property (
        !addressed_o |-> !instrument_data_line_o)
        else $error("data line driven outside data phase");

    AST_LINE_BIT: assert property (
        (addressed_o && clk_rise && st_q.bit_cnt < 6'h2F && !strobe)
        |=> instrument_data_line_o ==
            st_q.frame[6'h2E - $past(st_q.bit_cnt)])
        else $error("wrong response bit after rising edge");

    AST_LINE_HOLD: assert property (
        (addressed_o && !clk_rise && !strobe) |=>
            $stable(instrument_data_line_o))
        else $error("response bit moved between rising edges");

    // ****************************************
    // checks on counters, latches and entry
    // ****************************************

    AST_SETTINGS_HOLD: assert property (
        (st_q.fsm != isp_pkg::ST_COMMIT) |=> $stable(settings_o))
        else $error("latches changed outside commit");

    AST_COMMIT_STALL: assert property (
        (st_q.fsm == isp_pkg::ST_COMMIT && !push_ready) |=>
            st_q.fsm == isp_pkg::ST_COMMIT && $stable(settings_o))
        else $error("commit did not wait for room in the stream");

    AST_SHORT_FRAME_DROP: assert property (
        (addressed_o && strobe && st_q.bit_cnt != isp_pkg::CNT_FRAME)
        |=> st_q.fsm == isp_pkg::ST_ADDR && $stable(settings_o))
        else $error("short frame was not dropped");

    AST_COMMIT_DONE: assert property (
        (st_q.fsm == isp_pkg::ST_COMMIT && push_ready) |=>
            st_q.fsm == isp_pkg::ST_ADDR)
        else $error("commit did not return to address phase");

    AST_SHORT_ADDR: assert property (
        (st_q.fsm == isp_pkg::ST_ADDR && strobe &&
         st_q.bit_cnt != isp_pkg::CNT_ADDR) |=>
            st_q.fsm == isp_pkg::ST_ADDR)
        else $error("address with wrong bit count accepted");

    AST_ACCEPT_NEEDS_HIT: assert property (
        (st_q.fsm == isp_pkg::ST_ADDR &&
         !(strobe && addr_hit && st_q.bit_cnt == isp_pkg::CNT_ADDR))
        |=> !addressed_o)
        else $error("data phase opened without a matching strobe");

    AST_ENTRY_CLEARS: assert property (
        $rose(addressed_o) |-> st_q.bit_cnt == '0)
        else $error("bit count not cleared on address accept");

    AST_ENTRY_BIT: assert property (
        $rose(addressed_o) |-> instrument_data_line_o ==
            st_q.frame[isp_pkg::FRAME_BITS-1])
        else $error("first response bit wrong on entry");

    AST_COUNT_STEP: assert property (
        (clk_rise && st_q.bit_cnt != isp_pkg::CNT_MAX) |=>
            st_q.bit_cnt == $past(st_q.bit_cnt) + 6'h01)
        else $error("bit count did not step on clock rise");

    AST_COUNT_STILL: assert property (
        (!clk_rise && !strobe) |=> $stable(st_q.bit_cnt))
        else $error("bit count moved without a clock rise");

    AST_EDGE_CLEAR: assert property (
        st_q.s2.clk |=> st_q.edge_cnt == 3'h0)
        else $error("toggle count not cleared by clock high");

    AST_FRAME_STABLE: assert property (
        (addressed_o && !strobe) |=> $stable(st_q.frame))
        else $error("returned word changed during data phase");

    COV_LOCAL_HIT: cover property ($rose(addressed_o) &&
                                   local_mode_i);
    COV_ADDR_HIT: cover property ($rose(addressed_o));
    COV_COMMIT: cover property (st_q.fsm == isp_pkg::ST_COMMIT &&
                                push_ready);
    COV_STALL: cover property (st_q.fsm == isp_pkg::ST_COMMIT &&
                               !push_ready);
    COV_SHORT_FRAME: cover property (addressed_o && strobe &&
                                     st_q.bit_cnt != isp_pkg::CNT_FRAME);
endmodule

// File: dv/isp_host_model.sv
// host side model that bit-bangs the three-line serial port
`timescale 1ns/1ns
module isp_host_model #(
    parameter int PHASE_NS = 400
) (
    output logic      bus_clock_line_o,
    output logic      host_data_line_o,
    input  wire logic instrument_data_line_i
);
    // ********************************
    // idle levels, clock stands still
    // ********************************
    initial begin
        bus_clock_line_o = 1'b0;
        host_data_line_o = 1'b0;
    end

    // one bit; returns the response bit seen just before the rise
    task automatic put_bit(input logic b, output logic r);
        bus_clock_line_o = 1'b0;
        host_data_line_o = b;
        #(PHASE_NS);
        r = instrument_data_line_i;
        bus_clock_line_o = 1'b1;
        #(PHASE_NS);
        bus_clock_line_o = 1'b0;
        #(PHASE_NS/4);
        host_data_line_o = 1'b0;
        #(PHASE_NS);
    endtask

    // clock low, data toggles three cycles
    task automatic strobe();
        bus_clock_line_o = 1'b0;
        repeat (6) begin
            #(PHASE_NS);
            host_data_line_o = ~host_data_line_o;
        end
        #(PHASE_NS);
    endtask

    task automatic send_addr(input logic [7:0] a, input int n);
        logic r;
        for (int i = n - 1; i >= 0; i--) begin
            put_bit(a[i], r);
        end
        strobe();
    endtask

    // first n frame bits exchanged msb first, then strobe
    task automatic swap(input logic [47:0] tx, input int n,
                        output logic [47:0] rx);
        logic r;
        rx = 48'h0;
        for (int i = 0; i < n; i++) begin
            put_bit(tx[47-i], r);
            rx[47-i] = r;
        end
        strobe();
    endtask
endmodule

// File: dv/isp_slave_test.sv
// self-checking testbench of the instrument serial slave port
`timescale 1ns/1ns
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    n_errors++; \
    $display("Error t=%0t got %h exp %h", $time, (got), (exp)); end end
module isp_slave_test;
    localparam logic [7:0]  UA = 8'hA5;
    localparam logic [47:0] PNL = 48'h0F0F_0F0F_0F0F;
    localparam int          LIMIT = 40000;
    logic        clk_sys_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        bus_clock_line;
    logic        host_data_line;
    logic        instrument_data_line;
    logic [7:0]  unit_address = UA;
    logic [16:0] reading = 17'h0;
    logic        local_mode = 1'b0;
    logic [47:0] panel_settings = PNL;
    logic [47:0] settings;
    logic        addressed;
    logic        frame_valid;
    logic        frame_ready = 1'b0;
    logic [47:0] frame_data;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    // ********************************
    // design and host model
    // ********************************
    isp_slave i_isp_slave (
        .clk_sys_i              (clk_sys_i),
        .reset_n_i              (reset_n_i),
        .bus_clock_line_i       (bus_clock_line),
        .host_data_line_i       (host_data_line),
        .instrument_data_line_o (instrument_data_line),
        .unit_address_i         (unit_address),
        .reading_i              (reading),
        .local_mode_i           (local_mode),
        .panel_settings_i       (panel_settings),
        .settings_o             (settings),
        .addressed_o            (addressed),
        .frame_valid_o          (frame_valid),
        .frame_ready_i          (frame_ready),
        .frame_data_o           (frame_data)
    );
    isp_host_model i_isp_host_model (
        .bus_clock_line_o       (bus_clock_line),
        .host_data_line_o       (host_data_line),
        .instrument_data_line_i (instrument_data_line)
    );

    // ********************************
    // clock, timeout and verdict
    // ********************************
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            wrap_up();
        end
    end

    // ********************************
    // helpers
    // ********************************
    task automatic wait_clks(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // full transaction; checks the returned frame
    task automatic xfer(input logic [16:0] rd, input logic loc,
                        input logic [47:0] tx, input logic [47:0] exp);
        logic [47:0] rx;
        @(posedge clk_sys_i);
        reading <= rd;
        local_mode <= loc;
        i_isp_host_model.send_addr(UA, 8);
        `CHK(addressed, 1'b1)
        i_isp_host_model.swap(tx, 48, rx);
        `CHK(rx, exp)
        wait_clks(4);
    endtask
    // pops one word from the frame buffer and checks it
    task automatic drain(input logic [47:0] exp);
        int n;
        n = 0;
        while (frame_valid !== 1'b1 && n < 50) begin
            @(negedge clk_sys_i);
            n++;
        end
        `CHK(frame_data, exp)
        @(posedge clk_sys_i);
        frame_ready <= 1'b1;
        @(posedge clk_sys_i);
        frame_ready <= 1'b0;
        wait_clks(2);
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_reset();
        `CHK(settings, 48'h0)
        `CHK(addressed, 1'b0)
        `CHK(instrument_data_line, 1'b0)
        `CHK(frame_valid, 1'b0)
    endtask
    task automatic t_refused_addr();
        i_isp_host_model.send_addr(8'h5A, 8);
        `CHK(addressed, 1'b0)
        `CHK(instrument_data_line, 1'b0)
        i_isp_host_model.send_addr(UA, 7);
        `CHK(addressed, 1'b0)
    endtask
    task automatic t_exchange();
        xfer(17'h1_2345, 1'b0, 48'h8123_4567_89AB, {17'h1_2345, 31'h0});
        `CHK(settings, 48'h8123_4567_89AB)
        `CHK(addressed, 1'b0)
        xfer(17'h0_9876, 1'b0, 48'hFEDC_BA98_7654,
             {17'h0_9876, 31'h4567_89AB});
        `CHK(settings, 48'hFEDC_BA98_7654)
    endtask
    task automatic t_abort();
        logic [47:0] rx;
        i_isp_host_model.send_addr(UA, 8);
        i_isp_host_model.swap(48'h1111_2222_3333, 47, rx);
        wait_clks(4);
        `CHK(settings, 48'hFEDC_BA98_7654)
        `CHK(addressed, 1'b0)
    endtask
    task automatic t_local();
        xfer(17'h1_0005, 1'b1, 48'h5555_AAAA_5555, {17'h1_0005, PNL[30:0]});
        `CHK(settings, 48'h5555_AAAA_5555)
    endtask
    task automatic t_fifo_full();
        xfer(17'h0_0001, 1'b0, 48'h0123_0000_4567,
             {17'h0_0001, 31'h2AAA_5555});
        `CHK(settings, 48'h0123_0000_4567)
        xfer(17'h0_0002, 1'b0, 48'h3C3C_C3C3_3C3C,
             {17'h0_0002, 31'h0000_4567});
        `CHK(settings, 48'h0123_0000_4567)
        drain(48'h8123_4567_89AB);
        drain(48'hFEDC_BA98_7654);
        drain(48'h5555_AAAA_5555);
        drain(48'h0123_0000_4567);
        drain(48'h3C3C_C3C3_3C3C);
        `CHK(settings, 48'h3C3C_C3C3_3C3C)
        `CHK(frame_valid, 1'b0)
    endtask

    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        wait_clks(6);
        t_reset();
        t_refused_addr();
        t_exchange();
        t_abort();
        t_local();
        t_fifo_full();
        wrap_up();
    end
endmodule
